// >>> sccs_pkg.sv
// What this block does
// - Write: address with write bit is acked, then the start index N is acked.
// - The write byte count X is acked before any register data moves.
// - Each write data byte is acked; it is stored only at index 0-3 or 7, others drop it.
// - Read: index written first, then repeated start and read address, acked.
// - Read returns byte count first, then registers from index N onward.
// - Bus address follows the latched address-select strap, for both directions.
// - Register 0 bits 2:1 enable the two outputs; 0 forces low, reset 1.
// - Register 1 bits 7:6 read back the latched spread strap level.
// - Register 1 bit 5 picks strap or software spread amount, reset 0.
// - Register 1 bits 4:3: 00 off, 01 -0.25%, 10 reserved, 11 -0.5%.
// - Software spread bits do nothing until register 1 bit 5 is 1.
// - Register 1 bits 1:0 pick output amplitude, reset value 10.
// - Register 2 bits 2:1 pick slow or fast edges per output, reset 1.
// - At -0.5% spread the centre is 99.75 MHz, period 10.02506 ns.
// - Register 7 byte count is sent as the first read byte and again when index 7 is read, reset eight bytes.
// - Register 4 is reserved and always reads FF.
package sccs_pkg;
	localparam logic [7:0] IDX_OE       = 8'h00;
	localparam logic [7:0] IDX_SPREAD   = 8'h01;
	localparam logic [7:0] IDX_EDGE     = 8'h02;
	localparam logic [7:0] IDX_REF      = 8'h03;
	localparam logic [7:0] IDX_RSVD     = 8'h04;
	localparam logic [7:0] IDX_REV      = 8'h05;
	localparam logic [7:0] IDX_DEV      = 8'h06;
	localparam logic [7:0] IDX_BCNT     = 8'h07;
	localparam int         OE_LSB       = 1;
	localparam int         RB_LSB       = 6;
	localparam int         OVR_BIT      = 5;
	localparam int         AMT_LSB      = 3;
	localparam int         AMP_LSB      = 0;
	localparam int         EDGE_LSB     = 1;
	localparam logic [1:0] OE_RST       = 2'h3;
	localparam logic       OVR_RST      = 1'h0;
	localparam logic [1:0] AMT_RST      = 2'h0;
	localparam logic [1:0] AMP_RST      = 2'h2;
	localparam logic [1:0] EDGE_RST     = 2'h3;
	localparam logic [7:0] REF_RST      = 8'h5F;
	localparam logic [4:0] BC_RST       = 5'h08;
	localparam logic [7:0] RSVD_VAL     = 8'hFF;
	localparam logic [1:0] AMT_RESERVED = 2'h2;
	localparam logic [1:0] SPREAD_OFF   = 2'h0;
	localparam logic [3:0] BYTE_BITS    = 4'h8;
	localparam logic [3:0] LAST_TX_BIT  = 4'h7;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam real        SS05_CTR_MHZ = 99.75;
	localparam real        SS05_PER_NS  = 10.02506;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_RX     = 3'h1,
		ST_RX_ACK = 3'h2,
		ST_TX     = 3'h3,
		ST_TX_ACK = 3'h4
	} sccs_state_e;

	typedef enum logic [1:0] {
		BK_ADDR  = 2'h0,
		BK_INDEX = 2'h1,
		BK_COUNT = 2'h2,
		BK_DATA  = 2'h3
	} sccs_kind_e;

	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} sccs_link_s;
endpackage

// >>> sccs_link_sync.sv
`timescale 1ns/1ps
module sccs_link_sync (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                scl_i,
	input  wire logic                sda_i,
	output sccs_pkg::sccs_link_s     ev_o
);
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] prev_q;
	logic [1:0] pin;

	assign pin = {scl_i, sda_i};

	// Two flops per pin, then one more stage for edge detection.
	for (genvar i = 0; i < 2; i++) begin : g_sync
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				meta_q[i] <= 1'h1;
				sync_q[i] <= 1'h1;
				prev_q[i] <= 1'h1;
			end else begin
				meta_q[i] <= pin[i];
				sync_q[i] <= meta_q[i];
				prev_q[i] <= sync_q[i];
			end
		end
	end

	// One driver for the whole event word.
	always_comb begin
		ev_o          = '0;
		ev_o.scl_rise = sync_q[1] & ~prev_q[1];
		ev_o.scl_fall = ~sync_q[1] & prev_q[1];
		ev_o.start    = sync_q[1] & prev_q[1] & prev_q[0] & ~sync_q[0];
		ev_o.stop     = sync_q[1] & prev_q[1] & ~prev_q[0] & sync_q[0];
		ev_o.sda      = sync_q[0];
	end
endmodule

// >>> sccs_top.sv
`timescale 1ns/1ps
module sccs_top #(
	parameter logic [6:0] BUS_ADDR_0 = 7'h50,
	parameter logic [6:0] BUS_ADDR_1 = 7'h52,
	// Identification values are arbitrary.
	parameter logic [7:0] REV_ID     = 8'h00,
	parameter logic [7:0] DEV_ID     = 8'h00
) (
	input  wire logic       CORE_CLK_I,
	input  wire logic       RST_I,
	input  wire logic       SCL_I,
	input  wire logic       SDA_I,
	output logic            SDA_O,
	output logic            SDA_OE_O,
	input  wire logic       ADDR_SEL_STRAP_I,
	input  wire logic [1:0] SPREAD_STRAP_I,
	output logic [1:0]      DIFF_OUT_EN_O,
	output logic [1:0]      SPREAD_AMOUNT_O,
	output logic [1:0]      AMPLITUDE_SEL_O,
	output logic [1:0]      EDGE_FAST_O
);
	sccs_pkg::sccs_link_s  ev;
	sccs_pkg::sccs_state_e state_q;
	sccs_pkg::sccs_kind_e  kind_q;
	logic [3:0] cnt_q;
	logic [7:0] shr_q;
	logic [7:0] tx_q;
	logic [7:0] idx_q;
	logic       rw_q;
	logic       oe_q;
	logic       sda_o_q;
	logic [2:0] strap_meta_q;
	logic [2:0] strap_sync_q;
	logic [1:0] settle_q;
	logic       latched_q;
	logic       addr_sel_q;
	logic [1:0] strap_rb_q;
	logic [1:0] out_en_q;
	logic       ovr_q;
	logic [1:0] amt_q;
	logic [1:0] amp_q;
	logic [1:0] edge_q;
	logic [7:0] ref_q;
	logic [4:0] bc_q;
	logic [1:0] spread_q;
	logic [6:0] my_addr;
	logic       byte_end;
	logic       addr_hit;
	logic       wr_stb;
	logic [7:0] rd_byte;
	logic [7:0] count_byte;
	logic [2:0] strap_pin;

	sccs_link_sync u_sync (
		.clk_i (CORE_CLK_I),
		.rst_i (RST_I),
		.scl_i (SCL_I),
		.sda_i (SDA_I),
		.ev_o  (ev)
	);

	assign strap_pin = {ADDR_SEL_STRAP_I, SPREAD_STRAP_I};

	// Strap pins pass two flops before they are latched.
	for (genvar i = 0; i < 3; i++) begin : g_strap
		always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
			if (RST_I) begin
				strap_meta_q[i] <= 1'h0;
				strap_sync_q[i] <= 1'h0;
			end else begin
				strap_meta_q[i] <= strap_pin[i];
				strap_sync_q[i] <= strap_meta_q[i];
			end
		end
	end

	// Straps are caught once, shortly after reset release.
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			settle_q   <= 2'h0;
			latched_q  <= 1'h0;
			addr_sel_q <= 1'h0;
			strap_rb_q <= 2'h0;
		end else if (!latched_q) begin
			settle_q <= settle_q + 2'h1;
			if (settle_q == sccs_pkg::STRAP_SETTLE) begin
				latched_q  <= 1'h1;
				addr_sel_q <= strap_sync_q[2];
				strap_rb_q <= strap_sync_q[1:0];
			end
		end
	end

	assign my_addr    = addr_sel_q ? BUS_ADDR_1 : BUS_ADDR_0;
	assign addr_hit   = shr_q[7:1] == my_addr;
	assign byte_end   = state_q == sccs_pkg::ST_RX && ev.scl_fall
		&& cnt_q == sccs_pkg::BYTE_BITS;
	assign wr_stb     = byte_end && kind_q == sccs_pkg::BK_DATA;
	assign count_byte = {3'h0, bc_q};

	// Read view of the register bank at the current index.
	always_comb begin
		unique case (idx_q)
			sccs_pkg::IDX_OE:     rd_byte = {5'h1F, out_en_q, 1'h1};
			sccs_pkg::IDX_SPREAD: rd_byte = {strap_rb_q, ovr_q, amt_q,
				1'h1, amp_q};
			sccs_pkg::IDX_EDGE:   rd_byte = {5'h1F, edge_q, 1'h1};
			sccs_pkg::IDX_REF:    rd_byte = ref_q;
			sccs_pkg::IDX_RSVD:   rd_byte = sccs_pkg::RSVD_VAL;
			sccs_pkg::IDX_REV:    rd_byte = REV_ID;
			sccs_pkg::IDX_DEV:    rd_byte = DEV_ID;
			sccs_pkg::IDX_BCNT:   rd_byte = count_byte;
			default:              rd_byte = 8'h00;
		endcase
	end

	// Byte-level protocol engine.
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_q <= sccs_pkg::ST_IDLE;
			kind_q  <= sccs_pkg::BK_ADDR;
			cnt_q   <= 4'h0;
			shr_q   <= 8'h00;
			tx_q    <= 8'h00;
			idx_q   <= 8'h00;
			rw_q    <= 1'h0;
			oe_q    <= 1'h0;
		end else if (ev.stop) begin
			state_q <= sccs_pkg::ST_IDLE;
			oe_q    <= 1'h0;
		end else if (ev.start) begin
			state_q <= sccs_pkg::ST_RX;
			kind_q  <= sccs_pkg::BK_ADDR;
			cnt_q   <= 4'h0;
			oe_q    <= 1'h0;
		end else begin
			unique case (state_q)
				sccs_pkg::ST_IDLE: begin
					oe_q <= 1'h0;
				end
				sccs_pkg::ST_RX: begin
					if (ev.scl_rise && cnt_q != sccs_pkg::BYTE_BITS) begin
						shr_q <= {shr_q[6:0], ev.sda};
						cnt_q <= cnt_q + 4'h1;
					end
					if (byte_end) begin
						if (kind_q == sccs_pkg::BK_ADDR && !addr_hit) begin
							state_q <= sccs_pkg::ST_IDLE;
						end else begin
							state_q <= sccs_pkg::ST_RX_ACK;
							oe_q    <= 1'h1;
						end
						if (kind_q == sccs_pkg::BK_ADDR) begin
							rw_q <= shr_q[0];
						end
						if (kind_q == sccs_pkg::BK_INDEX) begin
							idx_q <= shr_q;
						end
						if (kind_q == sccs_pkg::BK_DATA) begin
							idx_q <= idx_q + 8'h01;
						end
					end
				end
				sccs_pkg::ST_RX_ACK: begin
					if (ev.scl_fall) begin
						cnt_q <= 4'h0;
						if (kind_q == sccs_pkg::BK_ADDR && rw_q) begin
							state_q <= sccs_pkg::ST_TX;
							tx_q    <= count_byte;
							oe_q    <= ~count_byte[7];
						end else begin
							state_q <= sccs_pkg::ST_RX;
							oe_q    <= 1'h0;
							unique case (kind_q)
								sccs_pkg::BK_ADDR:  kind_q <= sccs_pkg::BK_INDEX;
								sccs_pkg::BK_INDEX: kind_q <= sccs_pkg::BK_COUNT;
								sccs_pkg::BK_COUNT: kind_q <= sccs_pkg::BK_DATA;
								sccs_pkg::BK_DATA:  kind_q <= sccs_pkg::BK_DATA;
							endcase
						end
					end
				end
				sccs_pkg::ST_TX: begin
					if (ev.scl_fall) begin
						if (cnt_q == sccs_pkg::LAST_TX_BIT) begin
							state_q <= sccs_pkg::ST_TX_ACK;
							oe_q    <= 1'h0;
						end else begin
							tx_q  <= {tx_q[6:0], 1'h0};
							oe_q  <= ~tx_q[6];
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				sccs_pkg::ST_TX_ACK: begin
					if (ev.scl_rise && ev.sda) begin
						state_q <= sccs_pkg::ST_IDLE;
					end else if (ev.scl_fall) begin
						state_q <= sccs_pkg::ST_TX;
						cnt_q   <= 4'h0;
						tx_q    <= rd_byte;
						oe_q    <= ~rd_byte[7];
						idx_q   <= idx_q + 8'h01;
					end
				end
				default: begin
					state_q <= sccs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Register bank writes.
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			out_en_q <= sccs_pkg::OE_RST;
			ovr_q    <= sccs_pkg::OVR_RST;
			amt_q    <= sccs_pkg::AMT_RST;
			amp_q    <= sccs_pkg::AMP_RST;
			edge_q   <= sccs_pkg::EDGE_RST;
			ref_q    <= sccs_pkg::REF_RST;
			bc_q     <= sccs_pkg::BC_RST;
		end else if (wr_stb) begin
			unique case (idx_q)
				sccs_pkg::IDX_OE: begin
					out_en_q <= shr_q[sccs_pkg::OE_LSB +: 2];
				end
				sccs_pkg::IDX_SPREAD: begin
					ovr_q <= shr_q[sccs_pkg::OVR_BIT];
					amt_q <= shr_q[sccs_pkg::AMT_LSB +: 2];
					amp_q <= shr_q[sccs_pkg::AMP_LSB +: 2];
				end
				sccs_pkg::IDX_EDGE: begin
					edge_q <= shr_q[sccs_pkg::EDGE_LSB +: 2];
				end
				sccs_pkg::IDX_REF: begin
					ref_q <= shr_q;
				end
				sccs_pkg::IDX_BCNT: begin
					bc_q <= shr_q[4:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Spread amount: strap code until software takes over.
	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			spread_q <= sccs_pkg::SPREAD_OFF;
		end else if (!ovr_q) begin
			spread_q <= strap_rb_q;
		end else if (amt_q == sccs_pkg::AMT_RESERVED) begin
			spread_q <= sccs_pkg::SPREAD_OFF;
		end else begin
			spread_q <= amt_q;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sda_o_q <= 1'h0;
		end else begin
			sda_o_q <= 1'h0;
		end
	end

	assign SDA_O           = sda_o_q;
	assign SDA_OE_O        = oe_q;
	assign DIFF_OUT_EN_O   = out_en_q;
	assign SPREAD_AMOUNT_O = spread_q;
	assign AMPLITUDE_SEL_O = amp_q;
	assign EDGE_FAST_O     = edge_q;

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	sequence s_addr_end;
		byte_end && kind_q == sccs_pkg::BK_ADDR;
	endsequence
	sequence s_data_end;
		byte_end && kind_q == sccs_pkg::BK_DATA;
	endsequence

	property p_addr_ack;
		s_addr_end and addr_hit |=> SDA_OE_O
			&& state_q == sccs_pkg::ST_RX_ACK;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("matching address not acked");

	property p_foreign_addr;
		s_addr_end and !addr_hit |=> !SDA_OE_O
			&& state_q == sccs_pkg::ST_IDLE;
	endproperty
	a_foreign_addr: assert property (p_foreign_addr)
		else $error("foreign address was acked");

	property p_count_ack;
		byte_end && kind_q == sccs_pkg::BK_COUNT |=> SDA_OE_O;
	endproperty
	a_count_ack: assert property (p_count_ack)
		else $error("byte count not acked");

	property p_oe_write;
		s_data_end and idx_q == sccs_pkg::IDX_OE
			|=> ##1 DIFF_OUT_EN_O == $past(shr_q[2:1], 2);
	endproperty
	a_oe_write: assert property (p_oe_write)
		else $error("output enable write lost");

	property p_idx_step;
		s_data_end |=> idx_q == $past(idx_q) + 8'h01;
	endproperty
	a_idx_step: assert property (p_idx_step)
		else $error("index did not advance");

	property p_spread_locked;
		!ovr_q [*2] |-> SPREAD_AMOUNT_O == $past(strap_rb_q);
	endproperty
	a_spread_locked: assert property (p_spread_locked)
		else $error("spread left strap while not overridden");

	property p_count_first;
		state_q == sccs_pkg::ST_RX_ACK && kind_q == sccs_pkg::BK_ADDR
			&& rw_q && ev.scl_fall && !ev.stop && !ev.start
			|=> tx_q == $past(count_byte) && state_q == sccs_pkg::ST_TX;
	endproperty
	a_count_first: assert property (p_count_first)
		else $error("read did not begin with byte count");

	property p_rsvd_ff;
		idx_q == sccs_pkg::IDX_RSVD |-> rd_byte == 8'hFF;
	endproperty
	a_rsvd_ff: assert property (p_rsvd_ff)
		else $error("reserved register not FF");

	property p_strap_hold;
		latched_q |=> $stable(strap_rb_q) && $stable(addr_sel_q);
	endproperty
	a_strap_hold: assert property (p_strap_hold)
		else $error("latched strap changed");
endmodule

// >>> sccs_host.sv
`timescale 1ns/1ps
module sccs_host (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_pull_o
);
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	task automatic hw(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		sda_pull_o <= 1'b0;
		hw(4);
		scl_o <= 1'b1;
		hw(8);
		sda_pull_o <= 1'b1;
		hw(8);
		scl_o <= 1'b0;
		hw(4);
	endtask

	// Stop: data rises while the clock is high; the clock then idles high.
	task automatic stop();
		sda_pull_o <= 1'b1;
		hw(4);
		scl_o <= 1'b1;
		hw(8);
		sda_pull_o <= 1'b0;
		hw(8);
	endtask

	task automatic bit_x(input logic b, output logic r);
		sda_pull_o <= ~b;
		hw(4);
		scl_o <= 1'b1;
		hw(4);
		r = sda_i;
		hw(4);
		scl_o <= 1'b0;
		hw(4);
	endtask

	// Sends a byte MSB first, then drives or releases the ninth bit.
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] r, output logic acked);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r[i]);
		end
		bit_x(last, a);
		acked = ~a;
	endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam logic [6:0] A0 = 7'h50;
	localparam logic [6:0] A1 = 7'h52;
	logic       clk;
	logic       rst;
	logic       addr_strap;
	logic [1:0] spread_strap;
	logic       scl;
	logic       host_pull;
	logic       sda_oe;
	logic       sda_o;
	logic [1:0] out_en;
	logic [1:0] spread;
	logic [1:0] amp;
	logic [1:0] edge_fast;
	wire        sda_w = ~(host_pull | sda_oe);
	logic [6:0] cur_addr;
	logic [7:0] mem [8];
	int         error_cnt = 0;
	int         samples_checked = 0;

	sccs_top #(.BUS_ADDR_0(A0), .BUS_ADDR_1(A1)) DUT (
		.CORE_CLK_I      (clk),
		.RST_I           (rst),
		.SCL_I           (scl),
		.SDA_I           (sda_w),
		.SDA_O           (sda_o),
		.SDA_OE_O        (sda_oe),
		.ADDR_SEL_STRAP_I(addr_strap),
		.SPREAD_STRAP_I  (spread_strap),
		.DIFF_OUT_EN_O   (out_en),
		.SPREAD_AMOUNT_O (spread),
		.AMPLITUDE_SEL_O (amp),
		.EDGE_FAST_O     (edge_fast)
	);
	sccs_host HOST (
		.clk_i     (clk),
		.sda_i     (sda_w),
		.scl_o     (scl),
		.sda_pull_o(host_pull)
	);

	initial clk = 1'b0;
	always #5 clk = ~clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic logic [1:0] exp_spread(input logic [7:0] r1);
		if (!r1[5])
			return r1[7:6];
		return (r1[4:3] == 2'h2) ? 2'h0 : r1[4:3];
	endfunction

	task automatic mirror(input int idx, input logic [7:0] v);
		case (idx)
			0, 2: mem[idx] = {5'h1F, v[2:1], 1'b1};
			1: mem[1] = {mem[1][7:6], v[5:3], 1'b1, v[1:0]};
			3: mem[3] = v;
			7: mem[7] = {3'h0, v[4:0]};
			default: ;
		endcase
	endtask

	task automatic chk_outs();
		chk({6'h0, out_en}, {6'h0, mem[0][2:1]});
		chk({6'h0, spread}, {6'h0, exp_spread(mem[1])});
		chk({6'h0, amp}, {6'h0, mem[1][1:0]});
		chk({6'h0, edge_fast}, {6'h0, mem[2][2:1]});
	endtask

	task automatic do_reset(input logic a, input logic [1:0] sp);
		@(posedge clk);
		rst <= 1'b1;
		addr_strap <= a;
		spread_strap <= sp;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (12) @(posedge clk);
		mem = '{8'hFF, {sp, 6'h06}, 8'hFF, 8'h5F, 8'hFF, 8'h00, 8'h00, 8'h08};
	endtask

	task automatic wr(input int n0, input int len, input logic fix,
		input logic [7:0] fv);
		logic [7:0] r;
		logic       a;
		logic [7:0] v;
		HOST.start();
		HOST.xfer({cur_addr, 1'b0}, 1'b1, r, a);
		chk({7'h0, a}, 8'h01);
		HOST.xfer(n0[7:0], 1'b1, r, a);
		chk({7'h0, a}, 8'h01);
		HOST.xfer(len[7:0], 1'b1, r, a);
		chk({7'h0, a}, 8'h01);
		for (int i = 0; i < len; i++) begin
			v = fix ? fv : 8'($urandom);
			HOST.xfer(v, 1'b1, r, a);
			chk({7'h0, a}, 8'h01);
			mirror(n0 + i, v);
		end
		HOST.stop();
		chk_outs();
	endtask

	task automatic rd(input int n0, input int len);
		logic [7:0] r;
		logic       a;
		HOST.start();
		HOST.xfer({cur_addr, 1'b0}, 1'b1, r, a);
		chk({7'h0, a}, 8'h01);
		HOST.xfer(n0[7:0], 1'b1, r, a);
		chk({7'h0, a}, 8'h01);
		HOST.start();
		HOST.xfer({cur_addr, 1'b1}, 1'b1, r, a);
		chk({7'h0, a}, 8'h01);
		HOST.xfer(8'hFF, 1'b0, r, a);
		chk(r, {3'h0, mem[7][4:0]});
		for (int i = 0; i < len; i++) begin
			HOST.xfer(8'hFF, i == len - 1, r, a);
			chk(r, mem[n0 + i]);
		end
		HOST.stop();
	endtask

	task automatic bad_addr(input logic [6:0] ad);
		logic [7:0] r;
		logic       a;
		HOST.start();
		HOST.xfer({ad, 1'b0}, 1'b1, r, a);
		chk({7'h0, a}, 8'h00);
		HOST.stop();
	endtask

	initial begin
		logic [1:0] sps [3];
		logic [7:0] cv [4];
		int         n0;
		sps = '{2'h0, 2'h1, 2'h3};
		cv = '{8'h18, 8'h38, 8'h30, 8'h28};
		rst = 1'b1;
		addr_strap = 1'b0;
		spread_strap = 2'h0;
		void'($urandom(32'hEAD3));
		for (int k = 0; k < 2; k++) begin
			do_reset(k[0], sps[$urandom % 3]);
			cur_addr = k ? A1 : A0;
			chk_outs();
			rd(0, 8);
			bad_addr(k ? A0 : A1);
			foreach (cv[i]) begin
				wr(1, 1, 1'b1, cv[i]);
			end
			wr(4, 1, 1'b1, 8'h00);
			wr(7, 1, 1'b1, 8'h03);
			rd(2, 3);
			for (int j = 0; j < 5; j++) begin
				n0 = $urandom % 8;
				wr(n0, 1 + $urandom % (8 - n0), 1'b0, 8'h00);
				n0 = $urandom % 8;
				rd(n0, 1 + $urandom % (8 - n0));
			end
			$display("test %0d done", k);
		end
		conclude();
	end

	initial begin
		#900000;
		error_cnt++;
		conclude();
	end
endmodule
